// ==== design/cmlc_pkg.sv ====
package cmlc_pkg;

  // ---------------------------------------------------------------
  // value format and fixed-point scaling
  // ---------------------------------------------------------------
  typedef logic signed [15:0] cmlc_val_t;
  localparam cmlc_val_t VMAX = 16'sh7fff;
  localparam cmlc_val_t VMIN = -16'sh7fff;
  localparam int GAIN_SHIFT = 8;    // gains are q8.8
  localparam int ALPHA_SHIFT = 16;  // filter coefficient is q0.16
  localparam cmlc_val_t PCT_FULL = 16'sh0064;

  // ---------------------------------------------------------------
  // drive operation modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MODE_CUR, MODE_SPD, MODE_POS, MODE_PSP} cmlc_mode_t;

  // one gain and limit set of the position pid
  typedef struct packed {
    cmlc_val_t kp;
    cmlc_val_t ki;
    cmlc_val_t kd;
    cmlc_val_t kdf;
    cmlc_val_t ilim;
    cmlc_val_t dlim;
    cmlc_val_t olim;
  } cmlc_pid_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int LOOP_HZ_DEF = 1000;
  localparam int LOOP_DIV_DEF = CLK_HZ / LOOP_HZ_DEF;

  // ---------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IX_MODE = 6'h00;   // [1:0] mode, [2] analog command source
  localparam logic [5:0] IX_DIV = 6'h01;    // clocks per loop tick
  localparam logic [5:0] IX_CKP = 6'h02;
  localparam logic [5:0] IX_CKI = 6'h03;
  localparam logic [5:0] IX_CIL = 6'h04;
  localparam logic [5:0] IX_COL = 6'h05;
  localparam logic [5:0] IX_CRMP = 6'h06;
  localparam logic [5:0] IX_SKP = 6'h07;
  localparam logic [5:0] IX_SKI = 6'h08;
  localparam logic [5:0] IX_SIL = 6'h09;
  localparam logic [5:0] IX_SOL = 6'h0a;
  localparam logic [5:0] IX_SRMP = 6'h0b;
  localparam logic [5:0] IX_PID = 6'h0c;    // seven words, position set
  localparam logic [5:0] IX_PSP = 6'h13;    // seven words, position-with-speed set
  localparam logic [5:0] IX_SFILT = 6'h1a;
  localparam logic [5:0] IX_TACC = 6'h1b;
  localparam logic [5:0] IX_TVMAX = 6'h1c;
  localparam logic [5:0] IX_TTGT = 6'h1d;
  localparam logic [5:0] IX_HCMD = 6'h1e;
  localparam logic [5:0] IX_ANA = 6'h1f;    // nine analog shadow words
  localparam int ANA_N = 9;
  localparam logic [5:0] IX_NCFG = 6'h28;
  localparam logic [5:0] IX_COMMIT = 6'h28;
  localparam logic [5:0] IX_ST_DUTY = 6'h30;
  localparam logic [5:0] IX_ST_SPDF = 6'h31;
  localparam logic [5:0] IX_ST_ACMD = 6'h32;
  localparam logic [5:0] IX_ST_TPOS = 6'h33;
  localparam logic [5:0] IX_ST_CREF = 6'h34;

endpackage

// ==== design/cmlc_core.sv ====
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module cmlc_core
  import cmlc_pkg::*;
#(
  parameter int LOOP_DIV = LOOP_DIV_DEF
)
(
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, words only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  input wire cmlc_val_t curFb, // measured current
  input wire cmlc_val_t spdFb, // measured speed sample
  input wire cmlc_val_t posFb, // measured position
  input wire cmlc_val_t anaIn, // analog command input
  input wire cmlc_val_t i2tLim, // i2t current limit
  output cmlc_val_t pwmDuty, // duty fraction of supply
  output logic loopTick // loop sample tick
);

  // ---------------------------------------------------------------
  // saturating arithmetic
  // ---------------------------------------------------------------
  function automatic cmlc_val_t sat16(input logic signed [47:0] x);
    if (x > 48'(VMAX))
      return VMAX;
    if (x < 48'(VMIN))
      return VMIN;
    return x[15:0];
  endfunction

  function automatic cmlc_val_t addS(input cmlc_val_t a, input cmlc_val_t b);
    return sat16(48'(a) + 48'(b));
  endfunction

  function automatic cmlc_val_t mulq(input cmlc_val_t a, input cmlc_val_t k);
    logic signed [47:0] p;
    p = 48'(a) * 48'(k);
    return sat16(p >>> GAIN_SHIFT);
  endfunction

  // symmetric clamp; a negative limit acts as zero
  function automatic cmlc_val_t clampS(input cmlc_val_t x, input cmlc_val_t lim);
    cmlc_val_t l;
    l = lim[15] ? '0 : lim;
    if (x > l)
      return l;
    if (x < -l)
      return -l;
    return x;
  endfunction

  // move r toward c by at most rate; rate zero jumps
  function automatic cmlc_val_t stepTo(input cmlc_val_t r, input cmlc_val_t c, input cmlc_val_t rate);
    logic signed [47:0] d;
    d = 48'(c) - 48'(r);
    if (rate <= 0)
      return c;
    if (d > 48'(rate))
      return addS(r, rate);
    if (d < -48'(rate))
      return addS(r, -rate);
    return c;
  endfunction

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [31:0] cfg_r [0:39];
  cmlc_val_t ana_r [0:ANA_N-1];
  logic wrPend_r;
  logic [5:0] wrIx_r;
  logic [31:0] hrdata_r;
  logic hreadyOut_r;

  function automatic cmlc_val_t cv(input logic [31:0] w);
    return w[15:0];
  endfunction

  // loop state
  logic [31:0] divCnt_r;
  logic tick_r;
  cmlc_val_t spdF_r, tPos_r, tVel_r, posI_r, errPrev_r, dF_r, spdRef_r, spdI_r;
  cmlc_val_t outerCur_r, curRef_r, curI_r, pwmDuty_r, anaCmd_r;
  logic dbState_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  // zero wait states: read data is registered during the address phase
  wire logic addrPh = hsel & htrans[1] & hready;
  wire logic [5:0] rdIx = haddr[7:2];
  wire logic inMap = (haddr[31:8] == 24'h00_0000);
  wire logic [31:0] rdWord =
    !inMap ? 32'h0000_0000 :
    (rdIx < IX_NCFG) ? cfg_r[rdIx] :
    (rdIx == IX_ST_DUTY) ? {16'h0000, pwmDuty_r} :
    (rdIx == IX_ST_SPDF) ? {16'h0000, spdF_r} :
    (rdIx == IX_ST_ACMD) ? {16'h0000, anaCmd_r} :
    (rdIx == IX_ST_TPOS) ? {16'h0000, tPos_r} :
    (rdIx == IX_ST_CREF) ? {16'h0000, curRef_r} : 32'h0000_0000;
  wire logic commitWr = wrPend_r & (wrIx_r == IX_COMMIT);

  // address phase capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPend_r <= 1'b0;
      wrIx_r <= 6'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyOut_r <= 1'b1;
    end
    else
    begin
      wrPend_r <= addrPh & hwrite & inMap;
      wrIx_r <= rdIx;
      hrdata_r <= (addrPh & !hwrite) ? rdWord : hrdata_r;
      hreadyOut_r <= 1'b1;
    end
  end

  // data phase write; only the divider holds more than 16 bits
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 40; i++)
        cfg_r[i] <= (6'(i) == IX_DIV) ? 32'(LOOP_DIV) : 32'h0000_0000;
    end
    else if (wrPend_r && wrIx_r < IX_NCFG)
      cfg_r[wrIx_r] <= (wrIx_r == IX_DIV) ? hwdata : {16'h0000, hwdata[15:0]};
  end

  // analog settings copied to the working set only on commit
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < ANA_N; i++)
        ana_r[i] <= '0;
    end
    else if (commitWr)
    begin
      for (int i = 0; i < ANA_N; i++)
        ana_r[i] <= cv(cfg_r[IX_ANA + 6'(i)]);
    end
  end

  sequence s_commit;
    wrPend_r && (wrIx_r == IX_COMMIT);
  endsequence
  sequence s_noCommit;
    !(wrPend_r && (wrIx_r == IX_COMMIT));
  endsequence
  a_commit_copy: assert property (s_commit |=> ana_r[0] == $past(cv(cfg_r[IX_ANA])))
    else $error("analog low point not taken on commit");
  a_commit_only: assert property (s_noCommit |=> $stable(ana_r[1]) && $stable(ana_r[6]))
    else $error("analog setting changed without commit");

  // ---------------------------------------------------------------
  // loop tick divider
  // ---------------------------------------------------------------
  wire logic [31:0] divVal = (cfg_r[IX_DIV] == 32'h0000_0000) ? 32'h0000_0001 : cfg_r[IX_DIV];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      divCnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end
    else
    begin
      divCnt_r <= (divCnt_r == 32'h0000_0000) ? divVal - 32'h0000_0001 : divCnt_r - 32'h0000_0001;
      tick_r <= (divCnt_r == 32'h0000_0000);
    end
  end

  a_tick_space: assert property (tick_r && divVal > 32'h0000_0001 |=> !tick_r)
    else $error("loop ticks too close together");

  // ---------------------------------------------------------------
  // analog command front end
  // ---------------------------------------------------------------
  wire cmlc_val_t inLo = ana_r[0];
  wire cmlc_val_t inHi = ana_r[1];
  wire cmlc_val_t cmLo = ana_r[2];
  wire cmlc_val_t cmHi = ana_r[3];
  wire cmlc_val_t dbCv = ana_r[4];
  wire cmlc_val_t dbCmd = ana_r[5];
  wire cmlc_val_t dbW = ana_r[6];
  wire cmlc_val_t dbHys = ana_r[7];
  wire logic dbEn = ana_r[8][0];
  wire logic signed [47:0] span = 48'(inHi) - 48'(inLo);
  wire logic signed [47:0] rise = (48'(anaIn) - 48'(inLo)) * (48'(cmHi) - 48'(cmLo));
  wire cmlc_val_t mapped =
    (anaIn >= inHi) ? cmHi :
    (anaIn <= inLo) ? cmLo :
    sat16(48'(cmLo) + rise / span);
  wire logic signed [47:0] dbDist0 = 48'(anaIn) - 48'(dbCv);
  wire logic signed [47:0] dbDist = dbDist0[47] ? -dbDist0 : dbDist0;
  wire logic signed [47:0] dbHalf = 48'(dbW) >>> 1;
  // only the part of the band inside the range applies
  wire logic inRange = (anaIn > inLo) && (anaIn < inHi);
  wire logic dbInside = dbDist <= dbHalf;
  wire logic dbBeyond = dbDist > dbHalf + 48'(dbHys);
  // hysteresis keeps the band held until the input clears edge plus margin
  wire logic dbOn = dbEn && inRange && (dbState_r ? !dbBeyond : dbInside);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dbState_r <= 1'b0;
      anaCmd_r <= '0;
    end
    else
    begin
      dbState_r <= dbOn;
      anaCmd_r <= dbOn ? dbCmd : mapped;
    end
  end

  a_db_hold: assert property (dbOn |=> anaCmd_r == $past(dbCmd))
    else $error("deadband command not held");

  // ---------------------------------------------------------------
  // mode, command and parameter selection
  // ---------------------------------------------------------------
  wire cmlc_mode_t mode = cmlc_mode_t'(cfg_r[IX_MODE][1:0]);
  wire cmlc_val_t cmd = cfg_r[IX_MODE][2] ? anaCmd_r : cv(cfg_r[IX_HCMD]);
  wire logic spdAct = (mode == MODE_SPD) || (mode == MODE_PSP);
  wire logic posAct = (mode == MODE_POS) || (mode == MODE_PSP);
  // the set is read straight from storage so a later write is seen at once
  wire logic [5:0] pgB = (mode == MODE_PSP) ? IX_PSP : IX_PID;
  wire cmlc_pid_t pg = '{kp: cv(cfg_r[pgB]), ki: cv(cfg_r[pgB + 6'd1]), kd: cv(cfg_r[pgB + 6'd2]),
    kdf: cv(cfg_r[pgB + 6'd3]), ilim: cv(cfg_r[pgB + 6'd4]), dlim: cv(cfg_r[pgB + 6'd5]),
    olim: cv(cfg_r[pgB + 6'd6])};
  wire cmlc_val_t i2tP = i2tLim[15] ? '0 : i2tLim;

  // ---------------------------------------------------------------
  // speed filter and trajectory
  // ---------------------------------------------------------------
  wire logic signed [47:0] alpha = 48'(signed'({1'b0, cfg_r[IX_SFILT][15:0]}));
  wire cmlc_val_t spdFN = sat16(48'(spdF_r) + (((48'(spdFb) - 48'(spdF_r)) * alpha) >>> ALPHA_SHIFT));
  wire cmlc_val_t tAcc = cv(cfg_r[IX_TACC]);
  wire cmlc_val_t tVmax = cv(cfg_r[IX_TVMAX]);
  wire logic signed [47:0] tDist = 48'(cv(cfg_r[IX_TTGT])) - 48'(tPos_r);
  wire logic signed [47:0] tAbs = tDist[47] ? -tDist : tDist;
  // brake once stopping distance v*v/(2a) reaches the remaining distance
  // zero acceleration means the speed jumps straight to the limit, so it never brakes
  wire logic tBrake = (tAcc > 0) && ((48'(tVel_r) * 48'(tVel_r)) >= ((48'(tAcc) * tAbs) <<< 1));
  wire cmlc_val_t tGoal = tBrake ? '0 : tDist[47] ? -tVmax : (tDist == 0) ? '0 : tVmax;
  wire cmlc_val_t tVelN = stepTo(tVel_r, tGoal, tAcc);
  wire cmlc_val_t tVelA = tVelN[15] ? -tVelN : tVelN;
  wire logic tArrive = tAbs <= 48'(tVelA);

  // ---------------------------------------------------------------
  // position pid
  // ---------------------------------------------------------------
  wire cmlc_val_t pErr = sat16(48'(tPos_r) - 48'(posFb));
  wire cmlc_val_t posIN = clampS(addS(posI_r, mulq(pErr, pg.ki)), pg.ilim);
  wire cmlc_val_t dRaw = mulq(sat16(48'(pErr) - 48'(errPrev_r)), pg.kd);
  wire cmlc_val_t kdf = pg.kdf[15] ? '0 : (pg.kdf > PCT_FULL) ? PCT_FULL : pg.kdf;
  // larger percentage keeps more of the previous derivative
  wire cmlc_val_t dFN = sat16((48'(dRaw) * 48'(PCT_FULL - kdf) + 48'(dF_r) * 48'(kdf)) / 48'(PCT_FULL));
  wire cmlc_val_t dCl = clampS(dFN, pg.dlim);
  // in position-with-speed this limit bounds the commanded speed
  wire cmlc_val_t posOut = clampS(addS(addS(mulq(pErr, pg.kp), posIN), dCl), pg.olim);

  // ---------------------------------------------------------------
  // speed pi
  // ---------------------------------------------------------------
  wire cmlc_val_t spdRefN =
    (mode == MODE_SPD) ? stepTo(spdRef_r, cmd, cv(cfg_r[IX_SRMP])) :
    (mode == MODE_PSP) ? posOut : '0;
  wire cmlc_val_t sErr = sat16(48'(spdRefN) - 48'(spdF_r));
  wire cmlc_val_t spdIN = clampS(addS(spdI_r, mulq(sErr, cv(cfg_r[IX_SKI]))), cv(cfg_r[IX_SIL]));
  wire cmlc_val_t spdOut = clampS(addS(mulq(sErr, cv(cfg_r[IX_SKP])), spdIN), cv(cfg_r[IX_SOL]));
  wire cmlc_val_t outerN = clampS(spdAct ? spdOut : posOut, i2tP);

  // speed filter and trajectory, once per tick
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      spdF_r <= '0;
      tPos_r <= '0;
      tVel_r <= '0;
    end
    else if (tick_r)
    begin
      spdF_r <= spdFN;
      tPos_r <= !posAct ? posFb : tArrive ? cv(cfg_r[IX_TTGT]) : addS(tPos_r, tVelN);
      tVel_r <= (!posAct || tArrive) ? '0 : tVelN;
    end
  end

  // position pid state; held at zero while its mode is off
  always_ff @(posedge mclk)
  begin
    if (rst || !posAct)
    begin
      posI_r <= '0;
      errPrev_r <= '0;
      dF_r <= '0;
    end
    else if (tick_r)
    begin
      posI_r <= posIN;
      errPrev_r <= pErr;
      dF_r <= dFN;
    end
  end

  // speed pi state and outer current demand
  always_ff @(posedge mclk)
  begin
    if (rst || mode == MODE_CUR)
    begin
      spdRef_r <= '0;
      spdI_r <= '0;
      outerCur_r <= '0;
    end
    else if (tick_r)
    begin
      spdRef_r <= spdRefN;
      spdI_r <= spdAct ? spdIN : '0;
      outerCur_r <= outerN;
    end
  end

  a_pos_int_limit: assert property (posI_r <= clampS(VMAX, pg.ilim) && posI_r >= -clampS(VMAX, pg.ilim))
    else $error("position integral beyond its limit");
  a_spd_out_limit: assert property (tick_r && mode == MODE_SPD |=> outerCur_r <= $past(cv(cfg_r[IX_SOL])))
    else $error("speed output beyond its limit");
  a_i2t_limit: assert property (tick_r && mode != MODE_CUR |=> outerCur_r <= $past(i2tP) && outerCur_r >= -$past(i2tP))
    else $error("outer current demand beyond i2t limit");
  a_inactive_zero: assert property (mode == MODE_CUR |=> spdI_r == 0 && posI_r == 0)
    else $error("idle loop integrator not cleared");

  // ---------------------------------------------------------------
  // current pi, every clock
  // ---------------------------------------------------------------
  wire cmlc_val_t cRmp = cv(cfg_r[IX_CRMP]);
  wire cmlc_val_t cErr = sat16(48'(curRef_r) - 48'(curFb));
  wire cmlc_val_t curIN = clampS(addS(curI_r, mulq(cErr, cv(cfg_r[IX_CKI]))), cv(cfg_r[IX_CIL]));
  wire cmlc_val_t dutyN = clampS(addS(mulq(cErr, cv(cfg_r[IX_CKP])), curIN), cv(cfg_r[IX_COL]));

  // ramp steps on ticks; a zero rate follows the command every clock
  always_ff @(posedge mclk)
  begin
    if (rst)
      curRef_r <= '0;
    else if (mode != MODE_CUR)
      curRef_r <= outerCur_r;
    else if (tick_r || cRmp == 0)
      curRef_r <= stepTo(curRef_r, cmd, cRmp);
  end

  // duty is a signed q15 fraction of the supply voltage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      curI_r <= '0;
      pwmDuty_r <= '0;
    end
    else
    begin
      curI_r <= curIN;
      pwmDuty_r <= dutyN;
    end
  end

  a_curint_limit: assert property (curI_r <= clampS(VMAX, cv(cfg_r[IX_CIL])) && curI_r >= -clampS(VMAX, cv(cfg_r[IX_CIL])))
    else $error("current integral beyond its limit");
  a_duty_limit: assert property ($stable(cfg_r[IX_COL]) |-> pwmDuty <= clampS(VMAX, cv(cfg_r[IX_COL])))
    else $error("pwm duty beyond output limit");
  a_ramp_pass: assert property (mode == MODE_CUR && cRmp == 0 |=> curRef_r == $past(cmd))
    else $error("zero current ramp did not pass command");

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyOut_r;
  assign hresp = 1'b0;
  assign pwmDuty = pwmDuty_r;
  assign loopTick = tick_r;

endmodule

// ==== bench/cmlc_plant.sv ====
`timescale 1ns/100ps
module cmlc_plant
  import cmlc_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset
  input wire cmlc_val_t pwmDuty, // duty demand from the core
  input wire cmlc_val_t anaSet, // level the analog source should show
  output cmlc_val_t curFb, // coil current
  output cmlc_val_t spdFb, // shaft speed
  output cmlc_val_t posFb, // shaft position
  output cmlc_val_t anaIn // analog command voltage
);
  // ---------------------------------------------------------------
  // weak motor model
  // ---------------------------------------------------------------
  // feedback stays far below big commands, so loops stay saturated
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      curFb <= '0;
      spdFb <= '0;
      posFb <= '0;
    end
    else
    begin
      curFb <= pwmDuty >>> 6;
      spdFb <= curFb >>> 2;
      // position kept small so a far target never looks reached
      posFb <= (posFb > 1000 || posFb < -1000) ? posFb : posFb + (spdFb >>> 6);
    end
  end

  // source is stiff: the level follows the request at once
  assign anaIn = anaSet;
endmodule

// ==== bench/tb_cascaded_motor_control_loops.sv ====
`timescale 1ns/100ps
module tb_cascaded_motor_control_loops
  import cmlc_pkg::*;
;
  localparam int DIVP = 8;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, loopTick;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cmlc_val_t curFb, spdFb, posFb, anaIn, anaSet, i2tLim, pwmDuty;
  int failures, samples_checked, cyc, n;
  int dbIn[5] = '{100, 140, 160, 120, 100};
  bit dbHold[5] = '{1, 1, 0, 0, 1};

  cmlc_core #(.LOOP_DIV(DIVP)) i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .curFb(curFb), .spdFb(spdFb), .posFb(posFb), .anaIn(anaIn),
    .i2tLim(i2tLim), .pwmDuty(pwmDuty), .loopTick(loopTick));
  cmlc_plant i_plant (.mclk(mclk), .rst(rst), .pwmDuty(pwmDuty), .anaSet(anaSet), .curFb(curFb),
    .spdFb(spdFb), .posFb(posFb), .anaIn(anaIn));

  // ---------------------------------------------------------------
  // clock, timeout and helpers
  // ---------------------------------------------------------------
  always #4 mclk = ~mclk;

  // far above the expected run, catches a stalled wait
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  function automatic logic [31:0] z(input int v);
    return {16'h0000, 16'(v)};
  endfunction

  // linear map of -1000..1000 onto -500..500, ends held
  function automatic int anaExp(input int x);
    if (x <= -1000) return -500;
    if (x >= 1000) return 500;
    return -500 + (x + 1000) * 1000 / 2000;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // address phase held until hready, then data phase until hready
  task automatic wr(input logic [5:0] ix, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0000_00, ix, 2'b00};
    hwrite <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [5:0] ix, output logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0000_00, ix, 2'b00};
    hwrite <= 1'b0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic waitTicks(input int k);
    repeat (k)
    begin
      do @(posedge mclk); while (loopTick !== 1'b1);
    end
  endtask

  // cycles from one tick pulse to the next
  task automatic period(output int p);
    waitTicks(1);
    p = 0;
    do
    begin
      @(posedge mclk);
      p++;
    end
    while (loopTick !== 1'b1 && p < 5000);
  endtask

  task automatic ana(input int x);
    anaSet <= 16'(x);
    repeat (4) @(posedge mclk);
    rd(IX_ST_ACMD, d);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    mclk = 0;
    rst = 1;
    hsel = 0;
    htrans = 2'b00;
    haddr = '0;
    hwrite = 0;
    hsize = 3'b010;
    hwdata = '0;
    anaSet = '0;
    i2tLim = 16'sh7fff;
    void'($urandom(32'hf08a_8973));
    repeat (10) @(posedge mclk);
    chk({hreadyout, hresp, loopTick, 16'(pwmDuty)}, {3'b100, 16'h0000});
    rst <= 1'b0;
    @(posedge mclk);
    rd(IX_DIV, d);
    chk(d, DIVP);
    period(n);
    chk(n, DIVP);
    wr(IX_DIV, 20);
    period(n);
    period(n);
    chk(n, 20);
    wr(IX_DIV, DIVP);
    rd(6'h3f, d);
    chk(d, 0);
    rd(IX_COMMIT, d);
    chk(d, 0);
    // analog front end, host command taken from it; shadow then commit
    wr(IX_MODE, 4);
    foreach (dbIn[i]) wr(IX_ANA + 6'(i), z(i == 0 ? -1000 : i == 1 ? 1000 : i == 2 ? -500 : i == 3 ? 500 : 0));
    ana(2000);
    chk(d, 0);
    wr(IX_COMMIT, 0);
    ana(2000);
    chk(d, z(500));
    foreach (dbIn[i]) wr(IX_ANA + 6'(i + 4), 0);
    foreach (dbHold[i]) ana(i < 2 ? 1000 - 2000 * i : 3000 - 6000 * (i & 1));
    chk(d, z(anaExp(3000)));
    ana(-1000);
    chk(d, z(-500));
    repeat (6)
    begin
      n = int'($urandom % 1000) * 2 - 1000;
      ana(n);
      chk(d, z(anaExp(n)));
    end
    ana(300);
    wr(IX_ANA + 6'd5, 7);
    wr(IX_ANA + 6'd6, 200);
    wr(IX_ANA + 6'd7, 50);
    wr(IX_ANA + 6'd8, 1);
    wr(IX_COMMIT, 0);
    foreach (dbIn[i])
    begin
      ana(dbIn[i]);
      chk(d, z(dbHold[i] ? 7 : anaExp(dbIn[i])));
    end
    // current loop: integral clamp, then output clamp both signs
    wr(IX_MODE, MODE_CUR);
    wr(IX_CKI, 32'h0000_0100);
    wr(IX_CIL, 300);
    wr(IX_COL, 2000);
    wr(IX_HCMD, 30000);
    repeat (50) @(posedge mclk);
    chk(z(pwmDuty), z(300));
    wr(IX_CKI, 0);
    wr(IX_CKP, 32'h0000_0100);
    wr(IX_COL, 1000);
    foreach (dbHold[i])
    begin
      wr(IX_HCMD, z(i[0] ? -30000 : 30000));
      repeat (20) @(posedge mclk);
      chk(z(pwmDuty), z(i[0] ? -1000 : 1000));
    end
    wr(IX_HCMD, 0);
    wr(IX_CRMP, 10);
    wr(IX_HCMD, 100);
    waitTicks(3);
    rd(IX_ST_CREF, d);
    chk(d > 0 && d <= 40, 1);
    waitTicks(15);
    rd(IX_ST_CREF, d);
    chk(d, 100);
    // speed loop with frozen filter: reference is the error itself
    wr(IX_HCMD, 0);
    wr(IX_MODE, MODE_SPD);
    wr(IX_SKP, 32'h0000_0100);
    wr(IX_SOL, 200);
    wr(IX_SFILT, 0);
    wr(IX_SRMP, 5);
    wr(IX_HCMD, 1000);
    waitTicks(3);
    rd(IX_ST_CREF, d);
    chk(d > 0 && d <= 20, 1);
    wr(IX_SRMP, 0);
    waitTicks(3);
    rd(IX_ST_CREF, d);
    chk(d, 200);
    i2tLim <= 16'sd100;
    waitTicks(3);
    rd(IX_ST_CREF, d);
    chk(d, 100);
    i2tLim <= 16'sh7fff;
    wr(IX_SKP, 0);
    wr(IX_SKI, 32'h0000_0100);
    wr(IX_SIL, 120);
    waitTicks(4);
    rd(IX_ST_CREF, d);
    chk(d, 120);
    rd(IX_ST_SPDF, d);
    chk(d, 0);
    // position pid straight into current, speed set left in place
    wr(IX_MODE, MODE_POS);
    wr(IX_PID, 32'h0000_0100);
    wr(IX_PID + 6'd6, 150);
    wr(IX_TACC, 0);
    wr(IX_TVMAX, 30000);
    wr(IX_TTGT, 20000);
    waitTicks(4);
    rd(IX_ST_TPOS, d);
    chk(d, 20000);
    rd(IX_ST_CREF, d);
    chk(d, 150);
    wr(IX_SKI, 0);
    wr(IX_SKP, 32'h0000_0100);
    wr(IX_SOL, 2000);
    wr(IX_PSP, 32'h0000_0100);
    wr(IX_PSP + 6'd6, 50);
    wr(IX_MODE, MODE_PSP);
    waitTicks(4);
    rd(IX_ST_CREF, d);
    chk(d, 50);
    give_verdict();
  end
endmodule
